// File: mlcd_checker.sv
module mlcd_checker
(
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic serialSelect,
    input  wire logic serialData,
    input  wire logic serialClock,
    input  wire logic externalPolarityToggle,
    input  wire logic displayEnable,
    input  wire logic polaritySourceStrap
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int GROUP_BITS = mlcd_pkg::ADDR_BITS + mlcd_pkg::LINE_PIXELS + mlcd_pkg::DUMMY_BITS;

    logic [15:0] sinceSelect;
    logic [15:0] highCount;
    logic [15:0] sinceRise;
    logic [15:0] bitCount;
    logic        clockPrev;
    logic        clockRise;
    logic        dummyBit;
    int          groupPos;

    // Serial clock edge and the position of the bit it samples within its line group.
    assign clockRise = serialClock & ~clockPrev;
    assign groupPos  = (int'(bitCount) - mlcd_pkg::HDR_BITS) % GROUP_BITS;
    assign dummyBit  = (bitCount > 16'h0002 && bitCount < 16'h0008)
                     || (bitCount > 16'h0007 && groupPos >= GROUP_BITS - mlcd_pkg::DUMMY_BITS);

    // Previous clock level for edge detection.
    always_ff @(posedge clk)
        clockPrev <= sys_rst ? 1'b0 : serialClock;

    // Cycles since select rose; saturates so a long frame cannot wrap it.
    always_ff @(posedge clk)
        if (sys_rst || !serialSelect) sinceSelect <= 16'h0000;
        else if (sinceSelect != 16'hffff) sinceSelect <= sinceSelect + 16'h0001;

    // Length of the current high phase of the serial clock.
    always_ff @(posedge clk)
        highCount <= (sys_rst || !serialClock) ? 16'h0000 : highCount + 16'h0001;

    // Cycles since the last rising clock edge, saturating between frames.
    always_ff @(posedge clk)
        if (sys_rst || clockRise) sinceRise <= 16'h0001;
        else if (sinceRise != 16'hffff) sinceRise <= sinceRise + 16'h0001;

    // Bits clocked in during the current frame.
    always_ff @(posedge clk)
        if (sys_rst || !serialSelect) bitCount <= 16'h0000;
        else if (clockRise) bitCount <= bitCount + 16'h0001;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_clock_idle; !serialSelect |-> !serialClock; endproperty
    a_clock_idle: assert property (p_clock_idle) else $error("serial clock active outside a frame");

    property p_select_setup; clockRise && bitCount == 16'h0000 |-> sinceSelect >= mlcd_pkg::SETUP_CYCLES; endproperty
    a_select_setup: assert property (p_select_setup) else $error("first clock edge too soon after select");

    property p_select_hold; $fell(serialSelect) |-> sinceRise >= mlcd_pkg::HOLD_CYCLES; endproperty
    a_select_hold: assert property (p_select_hold) else $error("select dropped too soon after last bit");

    property p_clock_high; $fell(serialClock) |-> highCount == mlcd_pkg::HALF_PERIOD; endproperty
    a_clock_high: assert property (p_clock_high) else $error("serial clock high phase has wrong length");

    property p_clock_period; clockRise && bitCount != 16'h0000 |-> sinceRise >= 2 * mlcd_pkg::HALF_PERIOD; endproperty
    a_clock_period: assert property (p_clock_period) else $error("serial clock period too short");

    property p_whole_groups; $fell(serialSelect) |-> bitCount >= mlcd_pkg::HDR_BITS && groupPos == 0; endproperty
    a_whole_groups: assert property (p_whole_groups) else $error("frame ended inside a line group");

    property p_dummy_low; clockRise && dummyBit |-> !serialData; endproperty
    a_dummy_low: assert property (p_dummy_low) else $error("dummy bit sent high");

    property p_data_steady; clockRise |-> $stable(serialData) ##1 $stable(serialData) [*8]; endproperty
    a_data_steady: assert property (p_data_steady) else $error("serial data moved at its clock edge");
endmodule

// File: mlcd_host.sv
module mlcd_host
(
    input  wire logic       clk,
    input  wire logic       sys_rst,
    mlcd_if.host            pins,
    input  wire logic       strapHigh,
    input  wire logic       showOn,
    input  wire logic       toggleIn,
    input  wire logic       polarity,
    input  wire logic       start,
    input  wire logic [1:0] command,
    input  wire logic [6:0] lineAddr,
    input  wire logic [95:0] linePixels,
    input  wire logic       lastLine,
    output logic            lineTaken,
    output logic            busy
);
    localparam int GB = mlcd_pkg::ADDR_BITS + mlcd_pkg::LINE_PIXELS + mlcd_pkg::DUMMY_BITS;

    typedef enum logic [2:0] {
        MLCD_H_IDLE,
        MLCD_H_SETUP,
        MLCD_H_HEADER,
        MLCD_H_GROUP,
        MLCD_H_TAIL,
        MLCD_H_HOLD
    } mlcd_hstate_e;

    mlcd_hstate_e hState;
    logic [mlcd_pkg::DIV_BITS-1:0] divCount;
    logic [mlcd_pkg::WAIT_BITS-1:0] waitCount;
    logic [7:0] bitIdx;
    logic [GB-1:0] groupShift;
    logic [7:0] headShift;
    logic isUpdate;
    logic moreLines;
    wire halfTick = divCount == mlcd_pkg::DIV_BITS'(mlcd_pkg::HALF_PERIOD - 1);

    // Divider is held at zero only in idle and runs through setup, header, group, tail and hold.
    always_ff @(posedge clk)
    begin
        if (sys_rst || hState == MLCD_H_IDLE || halfTick)
            divCount <= '0;
        else
            divCount <= divCount + mlcd_pkg::DIV_BITS'(1);
    end

    // Frame engine; data changes on the falling edge, panel samples rising.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            hState              <= MLCD_H_IDLE;
            waitCount           <= '0;
            bitIdx              <= '0;
            groupShift          <= '0;
            headShift           <= '0;
            isUpdate            <= 1'b0;
            moreLines           <= 1'b0;
            lineTaken           <= 1'b0;
            busy                <= 1'b0;
            pins.serialSelect   <= 1'b0;
            pins.serialData     <= 1'b0;
            pins.serialClock    <= 1'b0;
        end
        else
        begin
            lineTaken <= 1'b0;
            case (hState)
                MLCD_H_IDLE:
                    if (start)
                    begin
                        // Header: update, polarity, clear, then low dummy bits.
                        headShift <= {5'h00,
                                      command == 2'(mlcd_pkg::MLCD_CMD_CLEAR),
                                      polarity,
                                      command == 2'(mlcd_pkg::MLCD_CMD_UPDATE_ONE)
                                      || command == 2'(mlcd_pkg::MLCD_CMD_UPDATE_MULTI)};
                        isUpdate  <= command == 2'(mlcd_pkg::MLCD_CMD_UPDATE_ONE)
                                     || command == 2'(mlcd_pkg::MLCD_CMD_UPDATE_MULTI);
                        busy              <= 1'b1;
                        pins.serialSelect <= 1'b1;
                        waitCount         <= '0;
                        hState            <= MLCD_H_SETUP;
                    end
                MLCD_H_SETUP:
                begin
                    waitCount <= waitCount + mlcd_pkg::WAIT_BITS'(1);
                    if (waitCount == mlcd_pkg::WAIT_BITS'(mlcd_pkg::SETUP_CYCLES - 1))
                    begin
                        bitIdx          <= '0;
                        pins.serialData <= headShift[0];
                        hState          <= MLCD_H_HEADER;
                    end
                end
                MLCD_H_HEADER, MLCD_H_GROUP:
                    if (halfTick)
                    begin
                        pins.serialClock <= !pins.serialClock;
                        if (pins.serialClock)
                        begin
                            bitIdx <= bitIdx + 8'd1;
                            if (hState == MLCD_H_HEADER)
                            begin
                                pins.serialData <= headShift[bitIdx[2:0] + 3'd1];
                                if (bitIdx == 8'(mlcd_pkg::HDR_BITS - 1))
                                begin
                                    bitIdx <= '0;
                                    if (isUpdate)
                                    begin
                                        // Address lsb first, pixels, low dummy.
                                        groupShift      <= {8'h00, linePixels, lineAddr};
                                        pins.serialData <= lineAddr[0];
                                        moreLines       <= !lastLine;
                                        lineTaken       <= 1'b1;
                                        hState          <= MLCD_H_GROUP;
                                    end
                                    else
                                        hState <= MLCD_H_TAIL;
                                end
                            end
                            else if (bitIdx == 8'(GB - 1))
                            begin
                                bitIdx <= '0;
                                if (moreLines)
                                begin
                                    // Next group follows with no gap.
                                    groupShift      <= {8'h00, linePixels, lineAddr};
                                    pins.serialData <= lineAddr[0];
                                    moreLines       <= !lastLine;
                                    lineTaken       <= 1'b1;
                                end
                                else
                                    hState <= MLCD_H_TAIL;
                            end
                            else
                            begin
                                groupShift      <= groupShift >> 1;
                                pins.serialData <= groupShift[1];
                            end
                        end
                    end
                MLCD_H_TAIL:
                begin
                    pins.serialData <= 1'b0;
                    waitCount       <= '0;
                    hState          <= MLCD_H_HOLD;
                end
                MLCD_H_HOLD:
                begin
                    waitCount <= waitCount + mlcd_pkg::WAIT_BITS'(1);
                    if (waitCount == mlcd_pkg::WAIT_BITS'(mlcd_pkg::HOLD_CYCLES - 1))
                    begin
                        pins.serialSelect <= 1'b0;
                        busy              <= 1'b0;
                        hState            <= MLCD_H_IDLE;
                    end
                end
                default:
                    hState <= MLCD_H_IDLE;
            endcase
        end
    end

    // Static pins follow the user; timing of toggle and power steps is the user's.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pins.externalPolarityToggle <= 1'b0;
            pins.displayEnable          <= 1'b0;
            pins.polaritySourceStrap    <= 1'b0;
        end
        else
        begin
            pins.externalPolarityToggle <= toggleIn;
            pins.displayEnable          <= showOn;
            pins.polaritySourceStrap    <= strapHigh;
        end
    end
endmodule

// File: mlcd_if.sv
interface mlcd_if;
    logic serialSelect;
    logic serialData;
    logic serialClock;
    logic externalPolarityToggle;
    logic displayEnable;
    logic polaritySourceStrap;

    modport host
    (
        output serialSelect,
        output serialData,
        output serialClock,
        output externalPolarityToggle,
        output displayEnable,
        output polaritySourceStrap
    );

    modport panel
    (
        input  serialSelect,
        input  serialData,
        input  serialClock,
        input  externalPolarityToggle,
        input  displayEnable,
        input  polaritySourceStrap
    );
endinterface

// File: mlcd_panel.sv
// Functional notes
// - Update mode writes one addressed line.
// - Back-to-back line groups update each line.
// - Display mode keeps memory unchanged.
// - Clear flag erases memory to white.
// - Serial polarity flag drives common electrode.
// - Serial flag used only while strap low.
// - Dummy bits may be either level.
// - Shifted pixels wait in a line latch.
// - Next address capture commits previous line.
// - Host clears memory one period at power-on.
// - Host waits 30 us after latch init.
// - Host waits 30 us for polarity init.
// - Host clears, then waits, before power-off.
// - Toggle input slower than frame rate.
// - With strap low, polarity changes only by received flag.
// - Keep both polarity intervals about equal.
// - Strap selects toggle input or serial flag.
// - Display enable low shows white, keeps memory.
// - Toggle rising edge sets polarity; the panel takes it only while display enable is high.
// - Seven-bit address, lsb first, lines 1..96.
module mlcd_panel
(
    input  wire logic clk,
    input  wire logic sys_rst,
    mlcd_if.panel     pins,
    input  wire logic [6:0] readLine,
    output logic [95:0] readPixels,
    output logic        commonElectrodeLevel,
    output logic        showImage,
    output logic        frameError
);
    localparam int AW = mlcd_pkg::ADDR_BITS;
    localparam int PW = mlcd_pkg::LINE_PIXELS;
    localparam int GROUP_BITS = AW + PW + mlcd_pkg::DUMMY_BITS;

    typedef enum logic [1:0] {
        MLCD_P_IDLE,
        MLCD_P_HEADER,
        MLCD_P_LINES
    } mlcd_pstate_e;

    // Returns true when a line number lies in the panel.
    function automatic logic mlcd_line_ok(input logic [AW-1:0] n);
        mlcd_line_ok = (n != '0) && (n <= AW'(mlcd_pkg::LINE_COUNT));
    endfunction

    logic [PW-1:0] pixelMem [mlcd_pkg::LINE_COUNT];
    logic [mlcd_pkg::SYNC_DEPTH-1:0] selSync;
    logic [mlcd_pkg::SYNC_DEPTH-1:0] datSync;
    logic [mlcd_pkg::SYNC_DEPTH-1:0] clkSync;
    logic [mlcd_pkg::SYNC_DEPTH-1:0] togSync;
    logic [mlcd_pkg::SYNC_DEPTH-1:0] showSync;
    logic [mlcd_pkg::SYNC_DEPTH-1:0] strapSync;
    logic selStable;
    logic clkStable;
    logic togStable;
    logic datStable;
    mlcd_pstate_e pState;
    logic [7:0] bitCount;
    logic [2:0] headerBits;
    logic [AW-1:0] shiftAddr;
    logic [AW-1:0] heldAddr;
    logic [PW-1:0] lineLatch;
    logic latchFull;
    logic clearPending;
    logic togglePol;
    logic serialPol;

    // Each pin passes three flops; a level counts when taps two and three agree.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            selSync   <= '0;
            datSync   <= '0;
            clkSync   <= '0;
            togSync   <= '0;
            showSync  <= '0;
            strapSync <= '0;
        end
        else
        begin
            selSync   <= {selSync[1:0], pins.serialSelect};
            datSync   <= {datSync[1:0], pins.serialData};
            clkSync   <= {clkSync[1:0], pins.serialClock};
            togSync   <= {togSync[1:0], pins.externalPolarityToggle};
            showSync  <= {showSync[1:0], pins.displayEnable};
            strapSync <= {strapSync[1:0], pins.polaritySourceStrap};
        end
    end

    // Filtered levels hold until taps agree, which rejects one-cycle glitches.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            selStable <= 1'b0;
            clkStable <= 1'b0;
            togStable <= 1'b0;
            datStable <= 1'b0;
        end
        else
        begin
            if (selSync[1] == selSync[2])
                selStable <= selSync[2];
            if (clkSync[1] == clkSync[2])
                clkStable <= clkSync[2];
            if (togSync[1] == togSync[2])
                togStable <= togSync[2];
            if (datSync[1] == datSync[2])
                datStable <= datSync[2];
        end
    end

    wire clkRise = (clkSync[1] == clkSync[2]) && clkSync[2] && !clkStable;
    wire togRise = (togSync[1] == togSync[2]) && togSync[2] && !togStable;
    wire selOn   = selStable;
    // Bit position inside the current line group.
    wire [7:0] groupPos = bitCount;
    wire addrDone  = groupPos == 8'(AW - 1);
    wire pixelDone = groupPos == 8'(AW + PW - 1);
    wire groupDone = groupPos == 8'(GROUP_BITS - 1);

    // Frame sequencer samples data on each rising serial clock while selected.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            pState       <= MLCD_P_IDLE;
            bitCount     <= '0;
            headerBits   <= '0;
            shiftAddr    <= '0;
            heldAddr     <= '0;
            lineLatch    <= '0;
            latchFull    <= 1'b0;
            clearPending <= 1'b0;
            serialPol    <= 1'b0;
            frameError   <= 1'b0;
        end
        else if (!selOn)
        begin
            // A group cut short by deselect is dropped, not half-written.
            pState       <= MLCD_P_IDLE;
            bitCount     <= '0;
            latchFull    <= 1'b0;
            clearPending <= 1'b0;
            if (pState == MLCD_P_LINES && groupPos != 8'd0)
                frameError <= 1'b1;
        end
        else if (clkRise)
        begin
            case (pState)
                MLCD_P_IDLE, MLCD_P_HEADER:
                begin
                    pState   <= MLCD_P_HEADER;
                    bitCount <= bitCount + 8'd1;
                    if (bitCount < 8'(mlcd_pkg::HDR_DUMMY - 2))
                        headerBits[bitCount[1:0]] <= datStable;
                    if (bitCount == 8'(mlcd_pkg::HDR_BITS - 1))
                    begin
                        bitCount <= '0;
                        // Update flag opens line groups; otherwise only dummy bits follow.
                        if (headerBits[mlcd_pkg::HDR_UPDATE])
                            pState <= MLCD_P_LINES;
                        else
                            pState <= MLCD_P_IDLE;
                        clearPending <= headerBits[mlcd_pkg::HDR_CLEAR] && !headerBits[mlcd_pkg::HDR_UPDATE];
                        serialPol    <= headerBits[mlcd_pkg::HDR_POL];
                        frameError   <= 1'b0;
                    end
                end
                MLCD_P_LINES:
                begin
                    bitCount <= groupDone ? 8'd0 : bitCount + 8'd1;
                    if (groupPos < 8'(AW))
                        shiftAddr <= {datStable, shiftAddr[AW-1:1]};
                    if (addrDone)
                        heldAddr <= {datStable, shiftAddr[AW-1:1]};
                    if (groupPos >= 8'(AW) && groupPos < 8'(AW + PW))
                        lineLatch <= {datStable, lineLatch[PW-1:1]};
                    if (pixelDone)
                        latchFull <= 1'b1;
                    else if (addrDone)
                        latchFull <= 1'b0;
                end
                default:
                    pState <= MLCD_P_IDLE;
            endcase
        end
    end

    // A latched line is committed when the next address completes or the select drops on a group boundary.
    wire commitNext = clkRise && selOn && pState == MLCD_P_LINES && addrDone && latchFull;
    wire commitEnd  = !selOn && latchFull && pState == MLCD_P_LINES && groupPos == 8'd0;
    wire doCommit   = (commitNext || commitEnd) && mlcd_line_ok(heldAddr);

    // Pixel memory: line writes, whole clear, or untouched in display mode.
    always_ff @(posedge clk)
    begin
        if (clearPending && !selOn)
        begin
            for (int i = 0; i < mlcd_pkg::LINE_COUNT; i++)
                pixelMem[i] <= '0;
        end
        else if (doCommit)
            pixelMem[heldAddr - AW'(1)] <= lineLatch;
    end

    // Readout port; display enable low shows white without touching memory.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            readPixels <= '0;
            showImage  <= 1'b0;
        end
        else
        begin
            if (showSync[1] == showSync[2])
                showImage <= showSync[2];
            if (showImage && mlcd_line_ok(readLine))
                readPixels <= pixelMem[readLine - AW'(1)];
            else
                readPixels <= '0;
        end
    end

    // Rising toggle edges flip togglePol while display enable is high, whatever the strap picks.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            togglePol <= 1'b0;
        else if (togRise && showImage)
            togglePol <= !togglePol;
    end

    // Strap chooses the polarity source; the serial flag counts only when low.
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            commonElectrodeLevel <= 1'b0;
        else if (strapSync[1] == strapSync[2])
            commonElectrodeLevel <= strapSync[2] ? togglePol : serialPol;
    end
endmodule

// File: mlcd_pkg.sv
package mlcd_pkg;

    // Panel geometry.
    localparam int LINE_PIXELS = 96;
    localparam int LINE_COUNT  = 96;
    localparam int ADDR_BITS   = 7;
    localparam int DUMMY_BITS  = 8;
    localparam int HDR_DUMMY   = 5;

    // Frame header bit positions, sent first to last.
    localparam int HDR_UPDATE  = 0;
    localparam int HDR_POL     = 1;
    localparam int HDR_CLEAR   = 2;
    localparam int HDR_BITS    = 8;

    // Device-side pin synchroniser depth.
    localparam int SYNC_DEPTH  = 3;

    // Host serial clock: 200 MHz system clock divided to 1 MHz.
    localparam int SYS_MHZ       = 200;
    localparam int SCLK_MHZ      = 1;
    localparam int HALF_PERIOD   = SYS_MHZ / (2 * SCLK_MHZ);
    localparam int DIV_BITS      = 8;

    // Select setup and hold around the bits, 3 us and 1 us least.
    localparam int SETUP_US      = 3;
    localparam int HOLD_US       = 1;
    localparam int SETUP_CYCLES  = SETUP_US * SYS_MHZ;
    localparam int HOLD_CYCLES   = HOLD_US * SYS_MHZ;
    localparam int WAIT_BITS     = 12;

    // Host power-on latch and polarity waits, 30 us least each.
    localparam int INIT_US       = 30;
    localparam int INIT_CYCLES   = INIT_US * SYS_MHZ;

    typedef enum logic [2:0] {
        MLCD_CMD_DISPLAY,
        MLCD_CMD_UPDATE_ONE,
        MLCD_CMD_UPDATE_MULTI,
        MLCD_CMD_CLEAR
    } mlcd_cmd_e;

endpackage

// File: tb_memory_lcd_serial_command_port.sv
module tb_memory_lcd_serial_command_port;
    timeunit 1ns;
    timeprecision 100ps;

    localparam logic [95:0] PIX_A = 96'h8000_0000_0000_0000_0000_0001;
    localparam logic [95:0] PIX_B = 96'ha5a5_5a5a_ffff_0000_1234_5678;
    localparam logic [95:0] PIX_C = 96'h5a5a_a5a5_0000_ffff_edcb_a987;

    logic        clk;
    logic        sys_rst;
    logic        strapHigh;
    logic        showOn;
    logic        toggleIn;
    logic        polarity;
    logic        start;
    logic [1:0]  command;
    logic [6:0]  lineAddr;
    logic [95:0] linePixels;
    logic        lastLine;
    logic        lineTaken;
    logic        busy;
    logic [6:0]  readLine;
    logic [95:0] readPixels;
    logic        comLevel;
    logic        showImage;
    logic        frameError;
    int          errCount;
    int          nChecks;

    mlcd_if bus ();

    mlcd_host i_mlcd_host
    (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .pins       (bus),
        .strapHigh  (strapHigh),
        .showOn     (showOn),
        .toggleIn   (toggleIn),
        .polarity   (polarity),
        .start      (start),
        .command    (command),
        .lineAddr   (lineAddr),
        .linePixels (linePixels),
        .lastLine   (lastLine),
        .lineTaken  (lineTaken),
        .busy       (busy)
    );

    mlcd_panel i_mlcd_panel
    (
        .clk                  (clk),
        .sys_rst              (sys_rst),
        .pins                 (bus),
        .readLine             (readLine),
        .readPixels           (readPixels),
        .commonElectrodeLevel (comLevel),
        .showImage            (showImage),
        .frameError           (frameError)
    );

    mlcd_checker i_mlcd_checker
    (
        .clk                    (clk),
        .sys_rst                (sys_rst),
        .serialSelect           (bus.serialSelect),
        .serialData             (bus.serialData),
        .serialClock            (bus.serialClock),
        .externalPolarityToggle (bus.externalPolarityToggle),
        .displayEnable          (bus.displayEnable),
        .polaritySourceStrap    (bus.polaritySourceStrap)
    );

    // Free-running 200 MHz clock.
    always #2.5 clk = ~clk;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic finishTest();
        $display("checks %0d, mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // One whole frame; the second line is handed over only after the first has been taken.
    task automatic frame(input logic [1:0] cmd, input logic pol, input logic [6:0] a0 = 7'h00,
                         input logic [95:0] d0 = '0, input logic [6:0] a1 = 7'h00, input logic [95:0] d1 = '0);
        int k;
        int taken = 0;
        command    = cmd;
        polarity   = pol;
        lineAddr   = a0;
        linePixels = d0;
        lastLine   = (cmd != 2'h2);
        start      = 1'b1;
        tick(1);
        start      = 1'b0;
        tick(1);
        for (k = 0; k < 60000 && busy !== 1'b0; k++)
        begin
            if (lineTaken === 1'b1)
                taken++;
            if (lineTaken === 1'b1 && cmd == 2'h2)
            begin
                tick(1);
                lineAddr   = a1;
                linePixels = d1;
                lastLine   = 1'b1;
            end
            tick(1);
        end
        if (k == 60000)
        begin
            check("busy", busy, 1'b0);
            finishTest();
        end
        check("lineTaken", taken, (cmd == 2'h2) ? 2 : int'(cmd == 2'h1));
        // The panel sees the pins through synchronisers, so give it time to settle.
        tick(12);
    endtask

    task automatic expectLine(input logic [6:0] ln, input logic [95:0] exp);
        readLine = ln;
        tick(3);
        check("readPixels", readPixels, exp);
    endtask

    task automatic scClear();
        frame(2'h3, 1'b0);
        expectLine(7'h01, '0);
        expectLine(7'h60, '0);
        check("frameError", frameError, 1'b0);
    endtask

    task automatic scUpdateOne();
        frame(2'h1, 1'b0, 7'h02, PIX_A);
        expectLine(7'h02, PIX_A);
        expectLine(7'h03, '0);
    endtask

    task automatic scUpdateMulti();
        frame(2'h2, 1'b0, 7'h60, PIX_B, 7'h01, PIX_C);
        expectLine(7'h60, PIX_B);
        expectLine(7'h01, PIX_C);
        expectLine(7'h02, PIX_A);
        check("comLevel", comLevel, 1'b0);
    endtask

    task automatic scPolarity();
        frame(2'h0, 1'b1);
        check("comLevel", comLevel, 1'b1);
        expectLine(7'h02, PIX_A);
        expectLine(7'h60, PIX_B);
        frame(2'h0, 1'b0);
        check("comLevel", comLevel, 1'b0);
    endtask

    // With the strap high only a rising toggle edge may move the common level.
    task automatic scStrap();
        logic lvl;
        strapHigh = 1'b1;
        tick(10);
        lvl = comLevel;
        frame(2'h0, ~lvl);
        check("comLevel", comLevel, lvl);
        toggleIn = 1'b1;
        tick(10);
        check("comLevel", comLevel, !lvl);
        toggleIn = 1'b0;
        tick(10);
        check("comLevel", comLevel, !lvl);
        strapHigh = 1'b0;
        tick(10);
    endtask

    task automatic scDisplayOff();
        showOn = 1'b0;
        tick(10);
        check("showImage", showImage, 1'b0);
        expectLine(7'h02, '0);
        showOn = 1'b1;
        tick(10);
        check("showImage", showImage, 1'b1);
        expectLine(7'h02, PIX_A);
    endtask

    // Main sequence: reset, one 30 us power-on wait, then every scenario in turn.
    initial
    begin
        clk        = 1'b0;
        sys_rst    = 1'b1;
        strapHigh  = 1'b0;
        showOn     = 1'b0;
        toggleIn   = 1'b0;
        polarity   = 1'b0;
        start      = 1'b0;
        command    = 2'h0;
        lineAddr   = 7'h00;
        linePixels = '0;
        lastLine   = 1'b0;
        readLine   = 7'h01;
        errCount   = 0;
        nChecks    = 0;
        tick(20);
        sys_rst = 1'b0;
        showOn  = 1'b1;
        tick(mlcd_pkg::INIT_CYCLES);
        scClear();
        scUpdateOne();
        scUpdateMulti();
        scPolarity();
        scStrap();
        scDisplayOff();
        scClear();
        finishTest();
    end
endmodule
